/* File: logic/rrdc_regs.svh */
// Offsets, field positions and reset values of the receiver and driver bank
`ifndef RRDC_REGS_SVH
`define RRDC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RRDC_OFF_N_OFF      8'h23
`define RRDC_OFF_RX_CFG     8'h26
`define RRDC_OFF_N_ON       8'h27
`define RRDC_OFF_P_UNMOD    8'h28

// ****************************************
// Reset values
// ****************************************
`define RRDC_RST_N_OFF      8'h88
`define RRDC_RST_RX_CFG     8'h48
`define RRDC_RST_N_ON       8'h88
`define RRDC_RST_P_UNMOD    6'h20

// ****************************************
// Field positions
// ****************************************
`define RRDC_AMP_BIT        7
`define RRDC_GAIN_HI        6
`define RRDC_GAIN_LO        4
`define RRDC_SENS_HI        3
`define RRDC_SENS_LO        0
`define RRDC_UNMOD_HI       7
`define RRDC_UNMOD_LO       4
`define RRDC_MOD_HI         3
`define RRDC_MOD_LO         0
`define RRDC_P_HI           5
`define RRDC_P_LO           0
`define RRDC_N_MSB          3
`define RRDC_P_MSB          5

// ****************************************
// Receiver gain steps in dB
// ****************************************
`define RRDC_DB_18          6'h12
`define RRDC_DB_23          6'h17
`define RRDC_DB_33          6'h21
`define RRDC_DB_38          6'h26
`define RRDC_DB_43          6'h2b
`define RRDC_DB_48          6'h30

`endif

/* File: logic/rrdc_pkg.sv */
// Types shared by the receiver and driver configuration bank
package rrdc_pkg;

    // ****************************************
    // Register selection
    // ****************************************
    typedef enum logic [2:0] {
        RRDC_SEL_NONE    = 3'b000,
        RRDC_SEL_N_OFF   = 3'b001,
        RRDC_SEL_RX_CFG  = 3'b010,
        RRDC_SEL_N_ON    = 3'b011,
        RRDC_SEL_P_UNMOD = 3'b100
    } rrdc_sel_t;

    // ****************************************
    // Complete state of the bank
    // ****************************************
    typedef struct packed {
        logic [7:0] rx_cfg;
        logic [7:0] n_on;
        logic [7:0] n_off;
        logic [5:0] p_unmod;
        logic [7:0] rd_data;
        logic       amp_en;
        logic [5:0] gain_db;
        logic [2:0] gain_code;
        logic [3:0] sens;
        logic       drv_active;
        logic [3:0] n_unmod;
        logic [3:0] n_mod;
        logic [5:0] p_cond;
    } rrdc_state_t;

endpackage

/* File: logic/rrdc_sync.sv */
// Two-stage synchroniser for asynchronous control levels
module rrdc_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ****************************************
    // Two flip-flop chain
    // ****************************************
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

/* File: logic/rrdc_bank.sv */
// Receiver gain, level detector and antenna driver conductance registers
//
// Overview of operation
// - Receiver register at 26h resets to 48h: amp enable bit 7, gain 6..4, sensitivity 3..0.
// - A 1 in the amp enable bit switches the level detector amplifier on, a 0 keeps it off.
// - Gain codes 000/010 give 18 dB, 001/011 23 dB, 100 33, 101 38, 110 43 and 111 48 dB.
// - The four sensitivity bits go to the level detector unchanged.
// - N-driver on-state register at 27h resets to 88h: unmodulated 7..4, modulated 3..0.
// - With either driver on the unmodulated N code comes from 27h, else from 23h.
// - With either driver on the modulated N code comes from 27h, else from 23h.
// - In soft power-down the top bit of each applied conductance code is forced to 1.
// - Every conductance code is plain binary, each bit twice the weight of the one below.
// - P-driver register at 28h resets to 20h and holds a six-bit code in bits 5..0.
// - Bits 7..6 of 28h read as 0 and ignore writes.
// - N-driver off-state register at 23h resets to 88h: unmodulated 7..4, modulated 3..0.
`include "rrdc_regs.svh"

module rrdc_bank
    import rrdc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    output logic      [7:0] rd_data_out,
    // Driver and power state
    input  wire logic       antenna_driver_one_on_in,
    input  wire logic       antenna_driver_two_on_in,
    input  wire logic       soft_power_down_in,
    // Receiver controls
    output logic            detector_amp_enable_out,
    output logic      [2:0] receiver_gain_code_out,
    output logic      [5:0] receiver_gain_db_out,
    output logic      [3:0] detector_sensitivity_out,
    // Driver conductance
    output logic            driver_active_out,
    output logic      [3:0] n_unmod_cond_out,
    output logic      [3:0] n_mod_cond_out,
    output logic      [5:0] p_unmod_cond_out
);

    // ****************************************
    // Declarations
    // ****************************************
    rrdc_state_t state_q;
    rrdc_state_t state_d;
    logic  [2:0] ctrl_sync;
    logic        drv_one_on;
    logic        drv_two_on;
    logic        pdown;
    rrdc_sel_t   wr_sel;
    rrdc_sel_t   rd_sel;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic rrdc_sel_t decode_addr(
        input logic [7:0] addr
    );
        rrdc_sel_t sel;
        sel = RRDC_SEL_NONE;
        if (addr == `RRDC_OFF_N_OFF) begin
            sel = RRDC_SEL_N_OFF;
        end else if (addr == `RRDC_OFF_RX_CFG) begin
            sel = RRDC_SEL_RX_CFG;
        end else if (addr == `RRDC_OFF_N_ON) begin
            sel = RRDC_SEL_N_ON;
        end else if (addr == `RRDC_OFF_P_UNMOD) begin
            sel = RRDC_SEL_P_UNMOD;
        end
        return sel;
    endfunction

    // ****************************************
    // Gain decode
    // ****************************************
    function automatic logic [5:0] gain_to_db(
        input logic [2:0] code
    );
        logic [5:0] db;
        db = `RRDC_DB_18;
        unique case (code)
            3'h0: begin
                db = `RRDC_DB_18;
            end
            3'h1: begin
                db = `RRDC_DB_23;
            end
            3'h2: begin
                db = `RRDC_DB_18;
            end
            3'h3: begin
                db = `RRDC_DB_23;
            end
            3'h4: begin
                db = `RRDC_DB_33;
            end
            3'h5: begin
                db = `RRDC_DB_38;
            end
            3'h6: begin
                db = `RRDC_DB_43;
            end
            3'h7: begin
                db = `RRDC_DB_48;
            end
        endcase
        return db;
    endfunction

    // ****************************************
    // Power-down forcing of the top code bit
    // ****************************************
    function automatic logic [3:0] force_n_msb(
        input logic [3:0] code,
        input logic       force_hi
    );
        logic [3:0] res;
        res = code;
        if (force_hi) begin
            res[`RRDC_N_MSB] = 1'b1;
        end
        return res;
    endfunction

    function automatic logic [5:0] force_p_msb(
        input logic [5:0] code,
        input logic       force_hi
    );
        logic [5:0] res;
        res = code;
        if (force_hi) begin
            res[`RRDC_P_MSB] = 1'b1;
        end
        return res;
    endfunction

    // ****************************************
    // Control level synchronisers
    // ****************************************
    rrdc_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .async_in ({soft_power_down_in,
                    antenna_driver_two_on_in,
                    antenna_driver_one_on_in}),
        .sync_out (ctrl_sync)
    );

    assign drv_one_on = ctrl_sync[0];
    assign drv_two_on = ctrl_sync[1];
    assign pdown      = ctrl_sync[2];

    // ****************************************
    // Strobe decode
    // ****************************************
    assign wr_sel = wr_en_in ? decode_addr(addr_in) : RRDC_SEL_NONE;
    assign rd_sel = rd_en_in ? decode_addr(addr_in) : RRDC_SEL_NONE;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;

        // Register writes
        unique case (wr_sel)
            RRDC_SEL_NONE: begin
                state_d.rx_cfg = state_q.rx_cfg;
            end
            RRDC_SEL_N_OFF: begin
                state_d.n_off = wr_data_in;
            end
            RRDC_SEL_RX_CFG: begin
                state_d.rx_cfg = wr_data_in;
            end
            RRDC_SEL_N_ON: begin
                state_d.n_on = wr_data_in;
            end
            RRDC_SEL_P_UNMOD: begin
                state_d.p_unmod = wr_data_in[`RRDC_P_HI:`RRDC_P_LO];
            end
            default: begin
                state_d.rx_cfg = state_q.rx_cfg;
            end
        endcase

        // Read data, valid only in the cycle after the strobe
        unique case (rd_sel)
            RRDC_SEL_NONE: begin
                state_d.rd_data = 8'h00;
            end
            RRDC_SEL_N_OFF: begin
                state_d.rd_data = state_q.n_off;
            end
            RRDC_SEL_RX_CFG: begin
                state_d.rd_data = state_q.rx_cfg;
            end
            RRDC_SEL_N_ON: begin
                state_d.rd_data = state_q.n_on;
            end
            RRDC_SEL_P_UNMOD: begin
                state_d.rd_data = {2'b00, state_q.p_unmod};
            end
            default: begin
                state_d.rd_data = 8'h00;
            end
        endcase

        // Receiver controls
        state_d.amp_en    = state_q.rx_cfg[`RRDC_AMP_BIT];
        state_d.gain_code = state_q.rx_cfg[`RRDC_GAIN_HI:`RRDC_GAIN_LO];
        state_d.gain_db   = gain_to_db(
            state_q.rx_cfg[`RRDC_GAIN_HI:`RRDC_GAIN_LO]);
        state_d.sens      = state_q.rx_cfg[`RRDC_SENS_HI:`RRDC_SENS_LO];

        // Driver conductance selection
        state_d.drv_active = drv_one_on | drv_two_on;
        if (drv_one_on | drv_two_on) begin
            state_d.n_unmod = force_n_msb(
                state_q.n_on[`RRDC_UNMOD_HI:`RRDC_UNMOD_LO], pdown);
            state_d.n_mod   = force_n_msb(
                state_q.n_on[`RRDC_MOD_HI:`RRDC_MOD_LO], pdown);
        end else begin
            state_d.n_unmod = force_n_msb(
                state_q.n_off[`RRDC_UNMOD_HI:`RRDC_UNMOD_LO], pdown);
            state_d.n_mod   = force_n_msb(
                state_q.n_off[`RRDC_MOD_HI:`RRDC_MOD_LO], pdown);
        end
        state_d.p_cond = force_p_msb(state_q.p_unmod, pdown);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q.rx_cfg     <= `RRDC_RST_RX_CFG;
            state_q.n_on       <= `RRDC_RST_N_ON;
            state_q.n_off      <= `RRDC_RST_N_OFF;
            state_q.p_unmod    <= `RRDC_RST_P_UNMOD;
            state_q.rd_data    <= 8'h00;
            state_q.amp_en     <= 1'b0;
            state_q.gain_db    <= `RRDC_DB_18;
            state_q.gain_code  <= 3'h0;
            state_q.sens       <= 4'h0;
            state_q.drv_active <= 1'b0;
            state_q.n_unmod    <= 4'h0;
            state_q.n_mod      <= 4'h0;
            state_q.p_cond     <= 6'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data_out              = state_q.rd_data;
    assign detector_amp_enable_out  = state_q.amp_en;
    assign receiver_gain_code_out   = state_q.gain_code;
    assign receiver_gain_db_out     = state_q.gain_db;
    assign detector_sensitivity_out = state_q.sens;
    assign driver_active_out        = state_q.drv_active;
    assign n_unmod_cond_out         = state_q.n_unmod;
    assign n_mod_cond_out           = state_q.n_mod;
    assign p_unmod_cond_out         = state_q.p_cond;

endmodule

/* File: tb/rrdc_bank_sva.sv */
// Assertions on the ports of the receiver and driver bank
module rrdc_bank_sva (
    // Clock and reset
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic       wr_en_in,
    input wire logic       rd_en_in,
    input wire logic [7:0] rd_data_out,
    // Driver and power state
    input wire logic       antenna_driver_one_on_in,
    input wire logic       antenna_driver_two_on_in,
    input wire logic       soft_power_down_in,
    // Outputs
    input wire logic       detector_amp_enable_out,
    input wire logic [2:0] receiver_gain_code_out,
    input wire logic [5:0] receiver_gain_db_out,
    input wire logic [3:0] detector_sensitivity_out,
    input wire logic       driver_active_out,
    input wire logic [3:0] n_unmod_cond_out,
    input wire logic [3:0] n_mod_cond_out,
    input wire logic [5:0] p_unmod_cond_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    amp_follow_a: assert property (
        wr_en_in && addr_in == 8'h26 |-> ##2 detector_amp_enable_out == $past(wr_data_in[7], 2)
    ) else $error("amp enable not from write");
    gain_follow_a: assert property (
        wr_en_in && addr_in == 8'h26 |-> ##2 receiver_gain_code_out == $past(wr_data_in[6:4], 2)
    ) else $error("gain code not from write");
    sens_follow_a: assert property (
        wr_en_in && addr_in == 8'h26 |-> ##2
        detector_sensitivity_out == $past(wr_data_in[3:0], 2)
    ) else $error("sensitivity not from write");
    gain_decode_a: assert property (
        receiver_gain_db_out == (receiver_gain_code_out[2] ?
            6'h21 + 6'h05 * {4'h0, receiver_gain_code_out[1:0]} :
            6'h12 + 6'h05 * {5'h00, receiver_gain_code_out[0]})
    ) else $error("gain decode wrong");
    p_reserved_a: assert property (
        rd_en_in && addr_in == 8'h28 |=> rd_data_out[7:6] == 2'b00
    ) else $error("reserved bits not zero");
    p_readback_a: assert property (
        wr_en_in && addr_in == 8'h28 ##1 rd_en_in && addr_in == 8'h28 |=>
        rd_data_out == {2'b00, $past(wr_data_in[5:0], 2)}
    ) else $error("p code readback wrong");
    rx_readback_a: assert property (
        wr_en_in && addr_in == 8'h26 ##1 rd_en_in && addr_in == 8'h26 |=>
        rd_data_out == $past(wr_data_in, 2)
    ) else $error("receiver readback wrong");
    pd_force_a: assert property (
        soft_power_down_in [*4] |->
        n_unmod_cond_out[3] && n_mod_cond_out[3] && p_unmod_cond_out[5]
    ) else $error("power-down top bits not forced");
    drv_active_a: assert property (
        (antenna_driver_one_on_in || antenna_driver_two_on_in) [*4] |-> driver_active_out
    ) else $error("driver active not raised");
endmodule

bind rrdc_bank rrdc_bank_sva i_rrdc_bank_sva (.*);

/* File: tb/tb_rrdc_bank.sv */
// Testbench for the receiver and driver configuration bank
module tb_rrdc_bank;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals and instance
    // ****************************************
    logic       mclk_in                  = 1'b0;
    logic       rst_n_in                 = 1'b0;
    logic [7:0] addr_in                  = 8'h00;
    logic [7:0] wr_data_in               = 8'h00;
    logic       wr_en_in                 = 1'b0;
    logic       rd_en_in                 = 1'b0;
    logic       antenna_driver_one_on_in = 1'b0;
    logic       antenna_driver_two_on_in = 1'b0;
    logic       soft_power_down_in       = 1'b0;
    logic [7:0] rd_data_out;
    logic       detector_amp_enable_out;
    logic [2:0] receiver_gain_code_out;
    logic [5:0] receiver_gain_db_out;
    logic [3:0] detector_sensitivity_out;
    logic       driver_active_out;
    logic [3:0] n_unmod_cond_out;
    logic [3:0] n_mod_cond_out;
    logic [5:0] p_unmod_cond_out;
    int         fail_count = 0;
    int         checks     = 0;
    logic [7:0] db_tab [8] = '{8'h12, 8'h17, 8'h12, 8'h17, 8'h21, 8'h26, 8'h2b, 8'h30};

    rrdc_bank i_rrdc_bank (.*);

    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en_in   <= 1'b1;
        addr_in    <= a;
        wr_data_in <= d;
        @(posedge mclk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b1;
        addr_in  <= a;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        @(negedge mclk_in);
        chk("rd_data_out", exp, rd_data_out);
        @(posedge mclk_in);
    endtask

    task automatic settle(input int n);
        wr_en_in <= 1'b0;
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic chk_rx(input logic [7:0] r);
        @(negedge mclk_in);
        chk("amp", {7'h00, r[7]}, {7'h00, detector_amp_enable_out});
        chk("gain", {5'h00, r[6:4]}, {5'h00, receiver_gain_code_out});
        chk("gain_db", db_tab[r[6:4]], {2'h0, receiver_gain_db_out});
        chk("sens", {4'h0, r[3:0]}, {4'h0, detector_sensitivity_out});
        @(posedge mclk_in);
    endtask

    task automatic drv(input logic [3:0] u, input logic [3:0] m, input logic [5:0] p);
        settle(4);
        @(negedge mclk_in);
        chk("n_unmod", {4'h0, u}, {4'h0, n_unmod_cond_out});
        chk("n_mod", {4'h0, m}, {4'h0, n_mod_cond_out});
        chk("p_unmod", {2'h0, p}, {2'h0, p_unmod_cond_out});
        chk("drv_active", {7'h00, antenna_driver_one_on_in | antenna_driver_two_on_in},
            {7'h00, driver_active_out});
        @(posedge mclk_in);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(8'h23, 8'h88);
        rd(8'h26, 8'h48);
        rd(8'h27, 8'h88);
        rd(8'h28, 8'h20);
        chk_rx(8'h48);
        drv(4'h8, 4'h8, 6'h20);
    endtask

    task automatic t_gain();
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            v = {c[0], c[2:0], c[2:0], ~c[0]};
            wr(8'h26, v);
            rd(8'h26, v);
            chk_rx(v);
        end
    endtask

    task automatic t_p_reg();
        wr(8'h28, 8'hff);
        rd(8'h28, 8'h3f);
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h00);
        rd(8'h23, 8'h88);
    endtask

    task automatic t_select();
        wr(8'h27, 8'h5a);
        wr(8'h23, 8'hc3);
        wr(8'h28, 8'h05);
        drv(4'hc, 4'h3, 6'h05);
        antenna_driver_one_on_in <= 1'b1;
        drv(4'h5, 4'ha, 6'h05);
        antenna_driver_one_on_in <= 1'b0;
        antenna_driver_two_on_in <= 1'b1;
        drv(4'h5, 4'ha, 6'h05);
        antenna_driver_one_on_in <= 1'b1;
        drv(4'h5, 4'ha, 6'h05);
        antenna_driver_one_on_in <= 1'b0;
        antenna_driver_two_on_in <= 1'b0;
        drv(4'hc, 4'h3, 6'h05);
        rd(8'h23, 8'hc3);
    endtask

    task automatic t_pdown();
        antenna_driver_one_on_in <= 1'b1;
        soft_power_down_in       <= 1'b1;
        drv(4'hd, 4'ha, 6'h25);
        rd(8'h27, 8'h5a);
        antenna_driver_one_on_in <= 1'b0;
        drv(4'hc, 4'hb, 6'h25);
        soft_power_down_in <= 1'b0;
        drv(4'hc, 4'h3, 6'h05);
    endtask

    initial begin
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_gain();
        t_p_reg();
        t_select();
        t_pdown();
        summarize();
    end

    initial begin
        repeat (2000) @(posedge mclk_in);
        fail_count++;
        summarize();
    end
endmodule
